// [sdram_command_bank_control.sv]
// command decoder and per-bank row state for a four-bank sdram
`timescale 1ns/1ps
// Functional notes
// - commands are taken only on the rising clock edge
// - decoding uses clock enable now and one cycle earlier
// - power-down request during a burst enters clock suspend instead
// - burst stop ends bursts of length 1, 2, 4, 8 or full page
// - activate is row strobe low, column high, write enable high
// - activate opens an idle bank and latches row from address 0 to 12
// - writes after activate are performed without bit mask while data mask is low
// - bank precharge is row low, column high, write low, address 10 low
// - bank precharge returns the named bank to idle
// - precharge every bank has address 10 high, bank select ignored
// - precharge every bank idles all four banks, legal when some idle
// - read is row high, column low, write high; address 10 auto precharge (the code only passes it out on cmdAutoPre, the bank stays open)
// - write is row high, column low, write low; address 10 auto precharge (the code only passes it out on cmdAutoPre, the bank stays open)
// - all commands ignored while chip select is high
module sdram_command_bank_control
   import sdram_cmd_pkg::*;
#(
   parameter int BANKS = NUM_BANKS
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command pins
   input wire logic clkEn,
   input wire logic chipSelect_n,
   input wire logic rowStrobe_n,
   input wire logic colStrobe_n,
   input wire logic writeEnable_n,
   input wire logic [BANK_W-1:0] bankSelect,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic dataMask,
   // burst length from mode setting
   input wire logic [BL_W-1:0] burstLenCode,
   // bank state
   output logic [BANKS-1:0] bankActive,
   output logic [ADDR_W-1:0] openRow [BANKS],
   output logic [1:0] devState,
   output logic burstActive,
   output logic writeUnmasked,
   // decoded command stream
   output logic cmdValid,
   input wire logic cmdReady,
   output logic [3:0] cmdCode,
   output logic [BANK_W-1:0] cmdBank,
   output logic [ADDR_W-1:0] cmdAddr,
   output logic cmdAutoPre
);
   localparam int EV_W = 4 + BANK_W + ADDR_W + 1;

   logic clkEnPrev_r;
   logic clkEnPrev_nxt;
   logic [BANKS-1:0] active_r;
   logic [BANKS-1:0] active_nxt;
   logic [ADDR_W-1:0] row_r [BANKS];
   logic [ADDR_W-1:0] row_nxt [BANKS];
   dev_state_t state_r;
   dev_state_t state_nxt;
   logic [COL_W:0] burstCnt_r;
   logic [COL_W:0] burstCnt_nxt;
   logic burst_r;
   logic burst_nxt;
   logic burstWr_r;
   logic burstWr_nxt;
   logic wrUnmask_r;
   logic wrUnmask_nxt;
   logic [2:0] strobes;
   cmd_t cmd;
   logic cmdLive;
   logic [EV_W-1:0] evData;
   logic [EV_W-1:0] bufData;
   logic bufValid;

   // sample-time decoding, qualified by the previous clock-enable level; current level picks refresh type
   always_comb
   begin
      strobes = {rowStrobe_n, colStrobe_n, writeEnable_n};
      cmd = CMD_NONE;
      cmdLive = (state_r == DEV_NORMAL) && clkEnPrev_r && !chipSelect_n;
      if (cmdLive)
      begin
         unique case (strobes)
            STROBE_ACT: cmd = CMD_ACT;
            STROBE_PRE: cmd = addr[AP_BIT] ? CMD_PREALL : CMD_PRE;
            STROBE_RD: cmd = CMD_RD;
            STROBE_WR: cmd = CMD_WR;
            STROBE_MRS: cmd = CMD_MRS;
            STROBE_REF: cmd = clkEn ? CMD_AREF : CMD_SREF;
            STROBE_BST: cmd = CMD_BST;
            STROBE_NOP: cmd = CMD_NONE;
         endcase
      end
   end

   // bank state next values
   always_comb
   begin
      active_nxt = active_r;
      row_nxt = row_r;
      wrUnmask_nxt = wrUnmask_r;
      if (cmd == CMD_ACT && !active_r[bankSelect])
      begin
         active_nxt[bankSelect] = 1'b1;
         row_nxt[bankSelect] = addr;
         wrUnmask_nxt = 1'b1;
      end
      else if (cmd == CMD_PRE)
      begin
         active_nxt[bankSelect] = 1'b0;
      end
      else if (cmd == CMD_PREALL)
      begin
         active_nxt = '0;
      end
      if (active_nxt == '0)
      begin
         wrUnmask_nxt = 1'b0;
      end
   end

   // burst tracking and device power state
   always_comb
   begin
      burst_nxt = burst_r;
      burstWr_nxt = burstWr_r;
      burstCnt_nxt = burstCnt_r;
      state_nxt = state_r;
      clkEnPrev_nxt = clkEn;
      if (burst_r && (state_r == DEV_NORMAL))
      begin
         if (burstCnt_r == '0)
         begin
            burst_nxt = (burstLenCode == BL_FULL);
         end
         else
         begin
            burstCnt_nxt = burstCnt_r - 1'b1;
         end
      end
      if ((cmd == CMD_RD || cmd == CMD_WR) && active_r[bankSelect])
      begin
         burst_nxt = 1'b1;
         burstWr_nxt = (cmd == CMD_WR);
         unique case (burstLenCode)
            3'h0: burstCnt_nxt = '0;
            3'h1: burstCnt_nxt = (COL_W+1)'(1);
            3'h2: burstCnt_nxt = (COL_W+1)'(3);
            3'h3: burstCnt_nxt = (COL_W+1)'(7);
            default: burstCnt_nxt = '0;
         endcase
      end
      if (cmd == CMD_BST || cmd == CMD_PRE || cmd == CMD_PREALL)
      begin
         burst_nxt = 1'b0;
      end
      unique case (state_r)
         DEV_NORMAL:
         begin
            if (clkEnPrev_r && !clkEn && cmd != CMD_SREF)
            begin
               state_nxt = (burst_r || burst_nxt) ? DEV_SUSPEND : DEV_POWERDOWN;
            end
            else if (cmd == CMD_SREF)
            begin
               state_nxt = DEV_SELFREF;
               burst_nxt = 1'b0;
            end
         end
         DEV_SUSPEND, DEV_POWERDOWN, DEV_SELFREF:
         begin
            if (!clkEnPrev_r && clkEn)
            begin
               state_nxt = DEV_NORMAL;
            end
         end
      endcase
   end

   // registers, taken on the rising edge only
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         clkEnPrev_r <= 1'b0;
         active_r <= '0;
         state_r <= DEV_NORMAL;
         burst_r <= 1'b0;
         burstWr_r <= 1'b0;
         burstCnt_r <= '0;
         wrUnmask_r <= 1'b0;
         for (int i = 0; i < BANKS; i++)
         begin
            row_r[i] <= '0;
         end
      end
      else
      begin
         clkEnPrev_r <= clkEnPrev_nxt;
         active_r <= active_nxt;
         state_r <= state_nxt;
         burst_r <= burst_nxt;
         burstWr_r <= burstWr_nxt;
         burstCnt_r <= burstCnt_nxt;
         wrUnmask_r <= wrUnmask_nxt;
         row_r <= row_nxt;
      end
   end

   // decoded command events through the buffer
   assign evData = {4'(cmd), bankSelect, addr, addr[AP_BIT]};

   cmd_skid_buffer #(
      .WIDTH(EV_W)
   ) u_buf (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(cmd != CMD_NONE),
      .inReady(),
      .inData(evData),
      .outValid(bufValid),
      .outReady(cmdReady || !cmdValid),
      .outData(bufData)
   );

   // registered outputs
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cmdValid <= 1'b0;
         cmdCode <= 4'h0;
         cmdBank <= '0;
         cmdAddr <= '0;
         cmdAutoPre <= 1'b0;
      end
      else if (cmdReady || !cmdValid)
      begin
         cmdValid <= bufValid;
         {cmdCode, cmdBank, cmdAddr, cmdAutoPre} <= bufData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         bankActive <= '0;
         devState <= 2'h0;
         burstActive <= 1'b0;
         writeUnmasked <= 1'b0;
         for (int i = 0; i < BANKS; i++)
         begin
            openRow[i] <= '0;
         end
      end
      else
      begin
         bankActive <= active_r;
         devState <= state_r;
         burstActive <= burst_r;
         writeUnmasked <= wrUnmask_r && burstWr_r && !dataMask;
         openRow <= row_r;
      end
   end

   // checks
   sequence actSeq;
      cmd == CMD_ACT && !active_r[bankSelect];
   endsequence

   AST_ACT_OPENS: assert property (@(posedge clk) disable iff (!rst_n)
      actSeq |=> active_r[$past(bankSelect)] && row_r[$past(bankSelect)] == $past(addr))
      else $error("activate did not open bank");
   AST_PRE_CLOSES: assert property (@(posedge clk) disable iff (!rst_n)
      cmd == CMD_PRE |=> !active_r[$past(bankSelect)])
      else $error("precharge did not close bank");
   AST_PREALL: assert property (@(posedge clk) disable iff (!rst_n)
      cmd == CMD_PREALL |=> active_r == '0 ##1 bankActive == '0)
      else $error("precharge all left a bank open");
   AST_CS_MASK: assert property (@(posedge clk) disable iff (!rst_n)
      chipSelect_n |-> cmd == CMD_NONE)
      else $error("command decoded with chip select high");
   AST_CKE_PREV: assert property (@(posedge clk) disable iff (!rst_n)
      !clkEnPrev_r |-> cmd == CMD_NONE)
      else $error("command decoded with previous clock enable low");
   AST_SUSPEND: assert property (@(posedge clk) disable iff (!rst_n)
      state_r == DEV_NORMAL && clkEnPrev_r && !clkEn && burst_r && cmd == CMD_NONE
      |=> state_r != DEV_POWERDOWN)
      else $error("power-down entered during burst");
   AST_BST: assert property (@(posedge clk) disable iff (!rst_n)
      cmd == CMD_BST |=> !burst_r ##1 !burstActive)
      else $error("burst stop ignored");
   AST_ACT_ENC: assert property (@(posedge clk) disable iff (!rst_n)
      cmd == CMD_ACT |-> !rowStrobe_n && colStrobe_n && writeEnable_n)
      else $error("activate decoded from wrong strobes");
   AST_UNMASK: assert property (@(posedge clk) disable iff (!rst_n)
      actSeq |=> wrUnmask_r)
      else $error("unmasked write not enabled after activate");
endmodule : sdram_command_bank_control

// [sdram_cmd_pkg.sv]
// constants and types for the sdram command and bank control block
package sdram_cmd_pkg;
   localparam int NUM_BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ADDR_W = 13;
   localparam int COL_W = 10;
   localparam int AP_BIT = 10;
   localparam int BL_W = 3;
   localparam logic [BL_W-1:0] BL_FULL = 3'h7;
   localparam logic [2:0] STROBE_ACT = 3'h3;
   localparam logic [2:0] STROBE_PRE = 3'h2;
   localparam logic [2:0] STROBE_RD = 3'h5;
   localparam logic [2:0] STROBE_WR = 3'h4;
   localparam logic [2:0] STROBE_MRS = 3'h0;
   localparam logic [2:0] STROBE_REF = 3'h1;
   localparam logic [2:0] STROBE_BST = 3'h6;
   localparam logic [2:0] STROBE_NOP = 3'h7;
   // operating states of the whole device
   typedef enum logic [1:0]
   {
      DEV_NORMAL = 2'b00,
      DEV_SUSPEND = 2'b01,
      DEV_POWERDOWN = 2'b10,
      DEV_SELFREF = 2'b11
   } dev_state_t;
   // decoded commands
   typedef enum logic [3:0]
   {
      CMD_NONE = 4'h0,
      CMD_ACT = 4'h1,
      CMD_PRE = 4'h2,
      CMD_PREALL = 4'h3,
      CMD_RD = 4'h4,
      CMD_WR = 4'h5,
      CMD_MRS = 4'h6,
      CMD_AREF = 4'h7,
      CMD_SREF = 4'h8,
      CMD_BST = 4'h9
   } cmd_t;
   localparam int BUF_DEPTH = 2;
endpackage : sdram_cmd_pkg

// [cmd_skid_buffer.sv]
// two-entry valid/ready buffer for decoded command events
`timescale 1ns/1ps
module cmd_skid_buffer
   import sdram_cmd_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] mem_r [BUF_DEPTH];
   logic [WIDTH-1:0] mem_nxt [BUF_DEPTH];
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic rdPtr_r;
   logic rdPtr_nxt;
   logic wrPtr_r;
   logic wrPtr_nxt;
   logic doWr;
   logic doRd;

   always_comb
   begin
      doWr = inValid && (count_r != 2'h2);
      doRd = outReady && (count_r != 2'h0);
      mem_nxt = mem_r;
      if (doWr)
      begin
         mem_nxt[wrPtr_r] = inData;
      end
      wrPtr_nxt = doWr ? ~wrPtr_r : wrPtr_r;
      rdPtr_nxt = doRd ? ~rdPtr_r : rdPtr_r;
      count_nxt = count_r + {1'b0, doWr} - {1'b0, doRd};
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         count_r <= 2'h0;
         rdPtr_r <= 1'b0;
         wrPtr_r <= 1'b0;
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end
      else
      begin
         count_r <= count_nxt;
         rdPtr_r <= rdPtr_nxt;
         wrPtr_r <= wrPtr_nxt;
         mem_r <= mem_nxt;
      end
   end

   assign inReady = (count_r != 2'h2);
   assign outValid = (count_r != 2'h0);
   assign outData = mem_r[rdPtr_r];
endmodule : cmd_skid_buffer

// [ctrl_model.sv]
// controller model that drives the command pins of the sdram block
`timescale 1ns/1ps
module ctrl_model
   import sdram_cmd_pkg::*;
#(
   parameter int ACT_GAP = 2
)
(
   // clock
   input wire logic clk,
   // command pins
   output logic clkEn,
   output logic chipSelect_n,
   output logic [2:0] strobes,
   output logic [BANK_W-1:0] bankSelect,
   output logic [ADDR_W-1:0] addr,
   output logic dataMask
);
   initial
   begin
      clkEn = 1'b1;
      chipSelect_n = 1'b1;
      strobes = STROBE_NOP;
      bankSelect = 2'h0;
      addr = 13'h0000;
      dataMask = 1'b0;
   end
   // deselect; released lines flip so stale values never look valid
   task idle();
      chipSelect_n = 1'b1;
      strobes = ~strobes;
      bankSelect = ~bankSelect;
      addr = ~addr;
      @(posedge clk);
      #1;
   endtask : idle
   // one command for one edge; activates are followed by spacing
   task issue(input logic cs, input logic [2:0] s, input logic [BANK_W-1:0] b,
      input logic [ADDR_W-1:0] a);
      chipSelect_n = cs;
      strobes = s;
      bankSelect = b;
      addr = a;
      @(posedge clk);
      #1;
      if (s == STROBE_ACT)
      begin
         repeat (ACT_GAP) idle();
      end
   endtask : issue
   task pins(input logic cke, input logic mask);
      clkEn = cke;
      dataMask = mask;
   endtask : pins
endmodule : ctrl_model

// [tb_sdram_command_bank_control.sv]
// self-checking testbench for the sdram command and bank control block
`timescale 1ns/1ps
module tb_sdram_command_bank_control;
   import sdram_cmd_pkg::*;
   logic clk;
   logic rst_n;
   logic cmdReady;
   logic [BL_W-1:0] burstLenCode;
   logic clkEn;
   logic chipSelect_n;
   logic [2:0] strobes;
   logic [BANK_W-1:0] bankSelect;
   logic [ADDR_W-1:0] addr;
   logic dataMask;
   logic [NUM_BANKS-1:0] bankActive;
   logic [ADDR_W-1:0] openRow [NUM_BANKS];
   logic [1:0] devState;
   logic burstActive;
   logic writeUnmasked;
   logic cmdValid;
   logic [3:0] cmdCode;
   logic [BANK_W-1:0] cmdBank;
   logic [ADDR_W-1:0] cmdAddr;
   logic cmdAutoPre;
   int failures;
   int comparisons;
   logic [19:0] evq [$];
   sdram_command_bank_control uut
   (
      .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .chipSelect_n(chipSelect_n),
      .rowStrobe_n(strobes[2]), .colStrobe_n(strobes[1]), .writeEnable_n(strobes[0]),
      .bankSelect(bankSelect), .addr(addr), .dataMask(dataMask),
      .burstLenCode(burstLenCode), .bankActive(bankActive), .openRow(openRow),
      .devState(devState), .burstActive(burstActive), .writeUnmasked(writeUnmasked),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdCode(cmdCode), .cmdBank(cmdBank),
      .cmdAddr(cmdAddr), .cmdAutoPre(cmdAutoPre)
   );
   ctrl_model ctrl
   (
      .clk(clk), .clkEn(clkEn), .chipSelect_n(chipSelect_n), .strobes(strobes),
      .bankSelect(bankSelect), .addr(addr), .dataMask(dataMask)
   );
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // collect every accepted command event
   always @(posedge clk)
   begin
      if ({rst_n, cmdValid, cmdReady} === 3'h7)
      begin
         evq.push_back({cmdCode, cmdBank, cmdAddr, cmdAutoPre});
      end
   end
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test
   task ev(input cmd_t code, input logic [BANK_W-1:0] bank, input logic [ADDR_W-1:0] a,
      input logic ap);
      int i;
      logic [19:0] e;
      i = 0;
      while (evq.size() == 0 && i < 20)
      begin
         ctrl.idle();
         i++;
      end
      if (evq.size() == 0)
      begin
         failures++;
         end_of_test();
      end
      e = evq.pop_front();
      check("event", 16'({e[19:16], e[0]}), 16'({code, ap}));
      check("eventAddr", 16'(e[15:1]), 16'({bank, a}));
   endtask : ev
   task fresh();
      repeat (3) ctrl.idle();
      evq.delete();
   endtask : fresh
   task t_act();
      ctrl.issue(1'b0, STROBE_ACT, 2'h1, 13'h1ABC);
      check("bankActive", 16'(bankActive), 16'h2);
      check("openRow", 16'(openRow[1]), 16'h1ABC);
      ev(CMD_ACT, 2'h1, 13'h1ABC, 1'b0);
      $display("done activate");
   endtask : t_act
   task t_pre();
      ctrl.issue(1'b0, STROBE_ACT, 2'h0, 13'h0555);
      ctrl.issue(1'b0, STROBE_PRE, 2'h0, 13'h1BFF);
      repeat (2) ctrl.idle();
      check("bankActive", 16'(bankActive), 16'h2);
      ctrl.issue(1'b0, STROBE_ACT, 2'h0, 13'h0AAA);
      check("openRow", 16'(openRow[0]), 16'h0AAA);
      ctrl.issue(1'b0, STROBE_PRE, 2'h3, 13'h0400);
      repeat (2) ctrl.idle();
      check("bankActive", 16'(bankActive), 16'h0);
      $display("done precharge");
   endtask : t_pre
   task t_cs();
      fresh();
      ctrl.issue(1'b1, STROBE_ACT, 2'h2, 13'h0123);
      repeat (4) ctrl.idle();
      check("bankActive", 16'(bankActive), 16'h0);
      check("events", 16'(evq.size()), 16'h0);
      $display("done deselect");
   endtask : t_cs
   task t_burst();
      fresh();
      ctrl.issue(1'b0, STROBE_ACT, 2'h3, 13'h0F0F);
      ctrl.issue(1'b0, STROBE_WR, 2'h3, 13'h0010);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h1);
      check("writeUnmasked", 16'(writeUnmasked), 16'h1);
      ctrl.pins(1'b1, 1'b1);
      ctrl.idle();
      check("writeUnmasked", 16'(writeUnmasked), 16'h0);
      ctrl.pins(1'b1, 1'b0);
      ctrl.issue(1'b0, STROBE_BST, 2'h3, 13'h0000);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h0);
      ctrl.issue(1'b0, STROBE_RD, 2'h3, 13'h0410);
      ev(CMD_ACT, 2'h3, 13'h0F0F, 1'b1);
      ev(CMD_WR, 2'h3, 13'h0010, 1'b0);
      ev(CMD_BST, 2'h3, 13'h0000, 1'b0);
      ev(CMD_RD, 2'h3, 13'h0410, 1'b1);
      $display("done burst");
   endtask : t_burst
   task t_cke();
      ctrl.issue(1'b0, STROBE_BST, 2'h3, 13'h0000);
      ctrl.pins(1'b0, 1'b0);
      repeat (3) ctrl.idle();
      check("devState", 16'(devState), 16'(DEV_POWERDOWN));
      ctrl.pins(1'b1, 1'b0);
      ctrl.issue(1'b0, STROBE_ACT, 2'h2, 13'h0002);
      check("bankActive", 16'(bankActive[2]), 16'h0);
      check("devState", 16'(devState), 16'(DEV_NORMAL));
      ctrl.issue(1'b0, STROBE_WR, 2'h3, 13'h0000);
      ctrl.idle();
      ctrl.pins(1'b0, 1'b0);
      repeat (3) ctrl.idle();
      check("devState", 16'(devState), 16'(DEV_SUSPEND));
      ctrl.pins(1'b1, 1'b0);
      repeat (3) ctrl.idle();
      check("devState", 16'(devState), 16'(DEV_NORMAL));
      ctrl.issue(1'b0, STROBE_BST, 2'h3, 13'h0000);
      $display("done clock enable");
   endtask : t_cke
   task t_ovf();
      ctrl.issue(1'b0, STROBE_PRE, 2'h0, 13'h0400);
      fresh();
      cmdReady = 1'b0;
      for (int b = 0; b < 4; b++)
      begin
         ctrl.issue(1'b0, STROBE_ACT, 2'(b), 13'h0100);
      end
      cmdReady = 1'b1;
      repeat (6) ctrl.idle();
      check("bankActive", 16'(bankActive), 16'hF);
      check("events", 16'(evq.size()), 16'h3);
      $display("done stall");
   endtask : t_ovf
   task t_ref();
      ctrl.issue(1'b0, STROBE_PRE, 2'h0, 13'h0400);
      fresh();
      ctrl.issue(1'b0, STROBE_MRS, 2'h0, 13'h0023);
      ctrl.issue(1'b0, STROBE_REF, 2'h0, 13'h0000);
      ctrl.pins(1'b0, 1'b0);
      ctrl.issue(1'b0, STROBE_REF, 2'h0, 13'h0000);
      repeat (2) ctrl.idle();
      check("devState", 16'(devState), 16'(DEV_SELFREF));
      ctrl.pins(1'b1, 1'b0);
      repeat (3) ctrl.idle();
      check("devState", 16'(devState), 16'(DEV_NORMAL));
      ev(CMD_MRS, 2'h0, 13'h0023, 1'b0);
      ev(CMD_AREF, 2'h0, 13'h0000, 1'b0);
      ev(CMD_SREF, 2'h0, 13'h0000, 1'b0);
      $display("done refresh");
   endtask : t_ref
   task t_len();
      fresh();
      ctrl.issue(1'b0, STROBE_ACT, 2'h1, 13'h0123);
      burstLenCode = 3'h2;
      ctrl.issue(1'b0, STROBE_WR, 2'h1, 13'h0004);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h1);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h1);
      ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h0);
      burstLenCode = 3'h3;
      ctrl.issue(1'b0, STROBE_WR, 2'h1, 13'h0004);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h1);
      ctrl.issue(1'b0, STROBE_BST, 2'h1, 13'h0000);
      repeat (2) ctrl.idle();
      check("burstActive", 16'(burstActive), 16'h0);
      burstLenCode = BL_FULL;
      ctrl.issue(1'b0, STROBE_PRE, 2'h1, 13'h0000);
      repeat (2) ctrl.idle();
      check("bankActive", 16'(bankActive), 16'h0);
      ev(CMD_ACT, 2'h1, 13'h0123, 1'b0);
      ev(CMD_WR, 2'h1, 13'h0004, 1'b0);
      ev(CMD_WR, 2'h1, 13'h0004, 1'b0);
      ev(CMD_BST, 2'h1, 13'h0000, 1'b0);
      ev(CMD_PRE, 2'h1, 13'h0000, 1'b0);
      $display("done burst length");
   endtask : t_len
   initial
   begin
      rst_n = 1'b0;
      cmdReady = 1'b1;
      burstLenCode = BL_FULL;
      failures = 0;
      comparisons = 0;
      repeat (8) @(posedge clk);
      #1;
      check("reset", 16'({bankActive, devState, cmdValid}), 16'h0);
      rst_n = 1'b1;
      repeat (2) ctrl.idle();
      t_act();
      t_pre();
      t_cs();
      t_burst();
      t_cke();
      t_ovf();
      t_ref();
      t_len();
      end_of_test();
   end
endmodule : tb_sdram_command_bank_control
